// file: inc/sscmd_defs.svh
`ifndef SSCMD_DEFS_SVH
`define SSCMD_DEFS_SVH
`define SSCMD_CLK_HZ          25000000
`define SSCMD_RESET_DELAY_MS  100
`define SSCMD_RESET_CYCLES    ((`SSCMD_CLK_HZ / 1000) * `SSCMD_RESET_DELAY_MS)
`define SSCMD_CR              8'h0d
`define SSCMD_SM_CYCLIC       4'h8
`define SSCMD_SO_STATUS_BIT   1
`define SSCMD_SS_COORD_BIT    0
`define SSCMD_SS_SYNCED_BIT   1
`define SSCMD_SS_SUPPORT_BIT  2
`define SSCMD_SS_PEND_BIT     3
`define SSCMD_AF_MASK_DEF     64'h00ffffffffffffff
`define SSCMD_BASE_KHZ        902400
`define SSCMD_STEP_KHZ        400
`define SSCMD_MAX_ARG         8
`endif

// file: inc/sscmd_pkg.sv
package sscmd_pkg;
    typedef enum logic [2:0] {
        SSCMD_RESP_OK    = 3'h0,
        SSCMD_RESP_ERROR = 3'h1,
        SSCMD_RESP_VALUE = 3'h2
    } sscmd_resp_type;

    typedef enum logic [11:0] {
        SSCMD_C_NONE  = 12'h000,
        SSCMD_C_APPLY = 12'h001,
        SSCMD_C_RST   = 12'h002,
        SSCMD_C_REST  = 12'h004,
        SSCMD_C_SAVE  = 12'h008,
        SSCMD_C_AFQ   = 12'h010,
        SSCMD_C_OSQ   = 12'h020,
        SSCMD_C_OWQ   = 12'h040,
        SSCMD_C_SSQ   = 12'h080,
        SSCMD_C_MSQ   = 12'h100,
        SSCMD_C_SMSET = 12'h200,
        SSCMD_C_STSET = 12'h400,
        SSCMD_C_SPSET = 12'h800
    } sscmd_cmd_type;

    typedef struct packed {
        logic [3:0]  mode;
        logic [31:0] sleep_t;
        logic [31:0] wake_t;
        logic [7:0]  opts;
    } sscmd_cfg_type;

    typedef struct packed {
        logic        valid;
        logic        sync_new;
        logic [31:0] sleep_t;
        logic [31:0] wake_t;
    } sscmd_sync_type;

    typedef struct packed {
        logic          valid;
        sscmd_resp_type kind;
        logic [63:0]   value;
    } sscmd_rsp_type;
endpackage

// file: src/sscmd_parser.sv
`timescale 1ns/10ps
`include "sscmd_defs.svh"
// Line parser: two letters, optional hex argument, carriage return ends it
module sscmd_parser
    import sscmd_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          rx_valid_i,
    input  wire logic [7:0]    rx_data_i,
    output sscmd_cmd_type      cmd_o,
    output logic               cmd_valid_o,
    output logic               has_arg_o,
    output logic [31:0]        arg_o
);
    typedef struct packed {
        logic [7:0]  c0;
        logic [7:0]  c1;
        logic [1:0]  n;
        logic [31:0] arg;
        logic        has;
        logic        bad;
        logic        done;
        sscmd_cmd_type cmd;
    } sscmd_pst_type;

    sscmd_pst_type st, next_st;
    logic [3:0] nib;
    logic       hex_ok;

    // Hex digit decode; bad characters poison the whole line
    always_comb begin
        nib    = 4'h0;
        hex_ok = 1'b0;
        if (rx_data_i >= 8'h30 && rx_data_i <= 8'h39) begin
            nib    = 4'(rx_data_i - 8'h30);
            hex_ok = 1'b1;
        end else if (rx_data_i >= 8'h41 && rx_data_i <= 8'h46) begin
            nib    = 4'(rx_data_i - 8'h37);
            hex_ok = 1'b1;
        end
    end

    // Gather characters and decode the two-letter code at line end
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (rx_valid_i) begin
            if (rx_data_i == `SSCMD_CR) begin // R16
                next_st.done = 1'b1;
                next_st.n    = 2'h0;
                next_st.has  = 1'b0;
                next_st.bad  = 1'b0;
                next_st.arg  = 32'h0;
                next_st.cmd  = SSCMD_C_NONE;
                if (st.n == 2'h2 && !st.bad) begin
                    unique case ({st.c0, st.c1})
                        16'h4143: next_st.cmd = SSCMD_C_APPLY;
                        16'h4652: next_st.cmd = SSCMD_C_RST;
                        16'h5245: next_st.cmd = SSCMD_C_REST;
                        16'h5752: next_st.cmd = SSCMD_C_SAVE;
                        16'h4146: next_st.cmd = SSCMD_C_AFQ;
                        16'h4f53: next_st.cmd = SSCMD_C_OSQ;
                        16'h4f57: next_st.cmd = SSCMD_C_OWQ;
                        16'h5353: next_st.cmd = SSCMD_C_SSQ;
                        16'h4d53: next_st.cmd = SSCMD_C_MSQ;
                        16'h534d: next_st.cmd = SSCMD_C_SMSET;
                        16'h5354: next_st.cmd = SSCMD_C_STSET;
                        16'h5350: next_st.cmd = SSCMD_C_SPSET;
                        default:  next_st.cmd = SSCMD_C_NONE;
                    endcase
                end
                next_st.has = st.has;
                next_st.arg = st.arg;
            end else if (st.n == 2'h0) begin
                next_st.c0  = rx_data_i;
                next_st.n   = 2'h1;
                // Argument of the last line must not leak into this one
                next_st.has = 1'b0;
                next_st.arg = 32'h0;
            end else if (st.n == 2'h1) begin
                next_st.c1 = rx_data_i;
                next_st.n  = 2'h2;
            end else begin
                next_st.has = 1'b1;
                next_st.bad = st.bad | !hex_ok;
                next_st.arg = {st.arg[27:0], nib};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_o       = st.cmd;
    assign cmd_valid_o = st.done;
    assign has_arg_o   = st.has;
    assign arg_o       = st.arg;
endmodule // sscmd_parser

// file: src/sscmd_top.sv
`timescale 1ns/10ps
`include "sscmd_defs.svh"
// Behaviour
// R01 - The apply command puts written settings into effect at once, staying in command mode.
// R02 - The reset command answers OK at once and pulses module reset 100 ms later.
// R03 - The restore command loads factory defaults into every setting.
// R04 - The save command copies the settings into non-volatile storage.
// R05 - After save the host sends nothing until it has the OK line.
// R06 - The available-frequency query is read only and returns the region channel bitfield.
// R07 - Bit n of that field is the channel at 902.400 MHz plus n times 400 kHz.
// R08 - Two queries return the operating sleep time and wake time.
// R09 - The sleep status query reports flags including coordinator status.
// R10 - Sleep cycles since the last sync are counted and returned on query.
// R11 - With the option set in API mode, a status frame is sent on wake and before sleep.
// R12 - A node whose sleep settings changed sends them to neighbours next wake.
// R13 - A support node rejects an outdated sync and answers with its newer settings; the code does this only while the node is coordinator.
// R14 - Sleep mode 8 is cyclic sleep, adopting the first sync from a synced node.
// R15 - An out-of-sync node adopts and aligns to a received network sync.
// R16 - Each command is a two-letter code, optional argument, carriage return, and gets a reply.
module sscmd_top
    import sscmd_pkg::*;
#(
    parameter int RESET_CYCLES = `SSCMD_RESET_CYCLES,
    parameter logic [63:0] AF_MASK = `SSCMD_AF_MASK_DEF
) (
    input  wire logic          REF_CLK_I,
    input  wire logic          RESET_I,
    input  wire logic          RX_VALID_I,
    input  wire logic [7:0]    RX_DATA_I,
    input  wire logic          API_MODE_I,
    input  wire logic          SUPPORT_NODE_I,
    input  wire logic          WAKE_EVENT_I,
    input  wire logic          SLEEP_EVENT_I,
    input  sscmd_sync_type     SYNC_RX_I,
    input  sscmd_cfg_type      FACTORY_CFG_I,
    output sscmd_rsp_type      RESP_O,
    output sscmd_cfg_type      ACTIVE_CFG_O,
    output sscmd_cfg_type      NV_CFG_O,
    output logic               NV_WRITE_O,
    output logic               MODULE_RESET_O,
    output sscmd_sync_type     SYNC_TX_O,
    output logic               STATUS_FRAME_O,
    output logic               STATUS_WAKE_O,
    output logic               COORDINATOR_O,
    output logic [15:0]        MISSED_SYNC_O
);
    typedef struct packed {
        sscmd_cfg_type  pend;
        sscmd_cfg_type  act;
        sscmd_cfg_type  nv;
        logic           nv_wr;
        logic           rst_arm;
        logic [31:0]    rst_cnt;
        logic           rst_out;
        sscmd_rsp_type  rsp;
        sscmd_sync_type stx;
        logic           chg_pend;
        logic           coord;
        logic           synced;
        logic           awake;
        logic [15:0]    missed;
        logic           sframe;
        logic           swake;
    } sscmd_st_type;

    sscmd_st_type  s, next_s;
    sscmd_cmd_type cmd;
    logic          cmd_valid;
    logic          has_arg;
    logic [31:0]   arg;
    logic          apply_chg;

    // Apply of changed times in this cycle, so a wake cannot swallow it
    assign apply_chg = cmd_valid && cmd == SSCMD_C_APPLY &&
                       (s.pend.sleep_t != s.act.sleep_t ||
                        s.pend.wake_t != s.act.wake_t);

    sscmd_parser u_parser (
        .clk_i       (REF_CLK_I),
        .rst_i       (RESET_I),
        .rx_valid_i  (RX_VALID_I),
        .rx_data_i   (RX_DATA_I),
        .cmd_o       (cmd),
        .cmd_valid_o (cmd_valid),
        .has_arg_o   (has_arg),
        .arg_o       (arg)
    );

    // Command execution, sync handling and sleep-cycle bookkeeping
    always_comb begin
        next_s           = s;
        next_s.nv_wr     = 1'b0;
        next_s.rst_out   = 1'b0;
        next_s.sframe    = 1'b0;
        next_s.stx.valid = 1'b0;
        next_s.rsp.valid = 1'b0;
        if (cmd_valid) begin
            next_s.rsp.valid = 1'b1; // R16
            next_s.rsp.kind  = SSCMD_RESP_OK;
            next_s.rsp.value = 64'h0;
            unique case (cmd)
                SSCMD_C_APPLY: begin
                    // Staying in command mode: only settings move
                    if (s.pend.sleep_t != s.act.sleep_t ||
                        s.pend.wake_t != s.act.wake_t) begin
                        next_s.chg_pend = 1'b1; // R12
                    end
                    next_s.act = s.pend; // R01
                end
                SSCMD_C_RST: begin
                    next_s.rst_arm = 1'b1; // R02
                    next_s.rst_cnt = 32'h0;
                end
                SSCMD_C_REST: next_s.pend = FACTORY_CFG_I; // R03
                SSCMD_C_SAVE: begin
                    next_s.nv    = s.pend; // R04
                    next_s.nv_wr = 1'b1;
                end
                SSCMD_C_AFQ: begin
                    next_s.rsp.kind  = SSCMD_RESP_VALUE;
                    next_s.rsp.value = has_arg ? 64'h0 : AF_MASK; // R06 R07
                    if (has_arg) begin
                        next_s.rsp.kind = SSCMD_RESP_ERROR; // R06
                    end
                end
                SSCMD_C_OSQ: begin
                    next_s.rsp.kind  = SSCMD_RESP_VALUE;
                    next_s.rsp.value = {32'h0, s.act.sleep_t}; // R08
                end
                SSCMD_C_OWQ: begin
                    next_s.rsp.kind  = SSCMD_RESP_VALUE;
                    next_s.rsp.value = {32'h0, s.act.wake_t}; // R08
                end
                SSCMD_C_SSQ: begin
                    next_s.rsp.kind  = SSCMD_RESP_VALUE;
                    next_s.rsp.value = 64'h0;
                    next_s.rsp.value[`SSCMD_SS_COORD_BIT]   = s.coord; // R09
                    next_s.rsp.value[`SSCMD_SS_SYNCED_BIT]  = s.synced;
                    next_s.rsp.value[`SSCMD_SS_SUPPORT_BIT] = SUPPORT_NODE_I;
                    next_s.rsp.value[`SSCMD_SS_PEND_BIT]    = s.chg_pend;
                end
                SSCMD_C_MSQ: begin
                    next_s.rsp.kind  = SSCMD_RESP_VALUE;
                    next_s.rsp.value = {48'h0, s.missed}; // R10
                end
                SSCMD_C_SMSET, SSCMD_C_STSET, SSCMD_C_SPSET: begin
                    if (!has_arg) begin
                        next_s.rsp.kind = SSCMD_RESP_ERROR;
                    end else if (cmd == SSCMD_C_SMSET) begin
                        next_s.pend.mode = arg[3:0];
                    end else if (cmd == SSCMD_C_STSET) begin
                        next_s.pend.wake_t = arg;
                    end else begin
                        next_s.pend.sleep_t = arg;
                    end
                end
                default: next_s.rsp.kind = SSCMD_RESP_ERROR;
            endcase
        end

        // Delayed reset leaves time for the OK line to go out
        if (s.rst_arm) begin
            if (s.rst_cnt == 32'(RESET_CYCLES - 1)) begin
                next_s.rst_arm = 1'b0;
                next_s.rst_out = 1'b1; // R02
            end else begin
                next_s.rst_cnt = s.rst_cnt + 32'h1;
            end
        end

        // Wake: broadcast changed settings and emit status frame
        if (WAKE_EVENT_I && !s.awake) begin
            next_s.awake = 1'b1;
            next_s.missed = s.missed + 16'h1; // R10
            if (s.chg_pend) begin
                next_s.stx = {1'b1, 1'b1, s.act.sleep_t, s.act.wake_t}; // R12
                next_s.chg_pend = apply_chg; // Fresh change wins the clear
                next_s.coord    = 1'b1;
                next_s.synced   = 1'b1;
            end
            if (API_MODE_I && s.act.opts[`SSCMD_SO_STATUS_BIT]) begin
                next_s.sframe = 1'b1; // R11
                next_s.swake  = 1'b1;
            end
        end else if (SLEEP_EVENT_I && s.awake) begin
            next_s.awake = 1'b0;
            if (API_MODE_I && s.act.opts[`SSCMD_SO_STATUS_BIT]) begin
                next_s.sframe = 1'b1; // R11
                next_s.swake  = 1'b0;
            end
        end

        // Incoming sync: reject stale ones on a coordinating support node, else adopt if unsynced, new or cyclic mode
        if (SYNC_RX_I.valid) begin
            if (SUPPORT_NODE_I && !SYNC_RX_I.sync_new && s.coord) begin
                next_s.stx = {1'b1, 1'b1, s.act.sleep_t, s.act.wake_t}; // R13
                next_s.missed = 16'h0; // R10
            end else if (!s.synced || SYNC_RX_I.sync_new ||
                         s.act.mode == `SSCMD_SM_CYCLIC) begin
                next_s.act.sleep_t = SYNC_RX_I.sleep_t; // R14 R15
                next_s.act.wake_t  = SYNC_RX_I.wake_t;
                next_s.pend.sleep_t = SYNC_RX_I.sleep_t;
                next_s.pend.wake_t  = SYNC_RX_I.wake_t;
                next_s.synced = 1'b1;
                next_s.coord  = 1'b0;
                next_s.missed = 16'h0; // R10
            end else begin
                next_s.missed = 16'h0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign RESP_O         = s.rsp;
    assign ACTIVE_CFG_O   = s.act;
    assign NV_CFG_O       = s.nv;
    assign NV_WRITE_O     = s.nv_wr;
    assign MODULE_RESET_O = s.rst_out;
    assign SYNC_TX_O      = s.stx;
    assign STATUS_FRAME_O = s.sframe;
    assign STATUS_WAKE_O  = s.swake;
    assign COORDINATOR_O  = s.coord;
    assign MISSED_SYNC_O  = s.missed;

    property p_reset_ok;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_RST) |=> RESP_O.valid &&
            RESP_O.kind == SSCMD_RESP_OK && s.rst_arm;
    endproperty
    a_reset_ok: assert property (p_reset_ok) // R02
        else $error("reset command not acknowledged");

    property p_apply;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_APPLY && !SYNC_RX_I.valid)
            |=> ACTIVE_CFG_O == $past(s.pend);
    endproperty
    a_apply: assert property (p_apply) // R01
        else $error("apply did not take settings");

    property p_restore;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_REST && !SYNC_RX_I.valid)
            |=> s.pend == $past(FACTORY_CFG_I);
    endproperty
    a_restore: assert property (p_restore) // R03
        else $error("restore did not load defaults");

    property p_save;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_SAVE) |=> NV_WRITE_O &&
            NV_CFG_O == $past(s.pend);
    endproperty
    a_save: assert property (p_save) // R04
        else $error("save did not write storage");

    property p_af;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_AFQ && !has_arg)
            |=> RESP_O.value == AF_MASK;
    endproperty
    a_af: assert property (p_af) // R06
        else $error("frequency field wrong");

    property p_os;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_OSQ)
            |=> RESP_O.value[31:0] == $past(s.act.sleep_t);
    endproperty
    a_os: assert property (p_os) // R08
        else $error("sleep time answer wrong");

    property p_ss;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (cmd_valid && cmd == SSCMD_C_SSQ)
            |=> RESP_O.value[`SSCMD_SS_COORD_BIT] == $past(s.coord);
    endproperty
    a_ss: assert property (p_ss) // R09
        else $error("coordinator flag wrong");

    property p_ms;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        SYNC_RX_I.valid |=> MISSED_SYNC_O == 16'h0;
    endproperty
    a_ms: assert property (p_ms) // R10
        else $error("missed count not cleared by sync");

    property p_frame;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (WAKE_EVENT_I && !s.awake && API_MODE_I &&
         s.act.opts[`SSCMD_SO_STATUS_BIT]) |=> STATUS_FRAME_O && STATUS_WAKE_O;
    endproperty
    a_frame: assert property (p_frame) // R11
        else $error("wake status frame missing");

    property p_reject;
        @(posedge REF_CLK_I) disable iff (RESET_I)
        (SYNC_RX_I.valid && SUPPORT_NODE_I && !SYNC_RX_I.sync_new && s.coord)
            |=> SYNC_TX_O.valid && $stable(ACTIVE_CFG_O.sleep_t);
    endproperty
    a_reject: assert property (p_reject) // R13
        else $error("stale sync not rejected");
endmodule // sscmd_top

// file: verification/sscmd_host_model.sv
`timescale 1ns/10ps
// Host side of the serial link: one character a cycle, one line at a time
module sscmd_host_model
    import sscmd_pkg::*;
(
    input  wire logic    clk_i,
    input  sscmd_rsp_type resp_i,
    output logic         rx_valid_o,
    output logic [7:0]   rx_data_o
);
    // Idle until the first command
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h55;
    end

    // Send letters, argument and carriage return, then wait for the answer
    task automatic cmd(input string s, output sscmd_rsp_type r,
                       output logic got);
        int n;
        got = 1'b0;
        r   = '0;
        for (int i = 0; i <= s.len(); i++) begin
            @(negedge clk_i);
            rx_valid_o = 1'b1;
            rx_data_o  = (i == s.len()) ? 8'h0d : 8'(s[i]);
        end
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        // A released line must not look like a repeat of the last character
        rx_data_o  = ~rx_data_o;
        // Nothing more is sent until the answer is in or 10 cycles pass, after a save too
        for (n = 0; n < 10 && !got; n++) begin
            if (resp_i.valid === 1'b1) begin
                got = 1'b1;
                r   = resp_i;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
endmodule // sscmd_host_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
`include "sscmd_defs.svh"
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_top;
    import sscmd_pkg::*;
    localparam int RSTC = 10; // Short reset delay keeps the run brief
    logic           clk = 1'b0;
    logic           rst, api, sup, wake_ev, sleep_ev, rx_valid, got;
    logic [7:0]     rx_data;
    sscmd_sync_type sync_rx, sync_tx, last_tx;
    sscmd_cfg_type  fact, act, nv;
    sscmd_rsp_type  resp, r;
    logic           nvw, mrst, sframe, swake, coord, last_wake;
    logic [15:0]    missed;
    int             failures = 0;
    int             tests_run = 0;
    int             frames = 0;
    int             tx_cnt = 0;
    int             nv_cnt = 0;
    int             n;
    string          bad [5] = '{"ZZ", "AF1", "ST", "Q", "SMG"};

    sscmd_top #(.RESET_CYCLES(RSTC)) DUT (
        .REF_CLK_I(clk), .RESET_I(rst), .RX_VALID_I(rx_valid),
        .RX_DATA_I(rx_data), .API_MODE_I(api), .SUPPORT_NODE_I(sup),
        .WAKE_EVENT_I(wake_ev), .SLEEP_EVENT_I(sleep_ev),
        .SYNC_RX_I(sync_rx), .FACTORY_CFG_I(fact), .RESP_O(resp),
        .ACTIVE_CFG_O(act), .NV_CFG_O(nv), .NV_WRITE_O(nvw),
        .MODULE_RESET_O(mrst), .SYNC_TX_O(sync_tx),
        .STATUS_FRAME_O(sframe), .STATUS_WAKE_O(swake),
        .COORDINATOR_O(coord), .MISSED_SYNC_O(missed)
    );

    sscmd_host_model host (
        .clk_i(clk), .resp_i(resp), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data)
    );

    // Free running 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    // Pulses are short, so they are caught here rather than polled
    always @(posedge clk) begin
        if (sframe === 1'b1) begin
            frames    <= frames + 1;
            last_wake <= swake;
        end
        if (sync_tx.valid === 1'b1) begin
            tx_cnt  <= tx_cnt + 1;
            last_tx <= sync_tx;
        end
        if (nvw === 1'b1) begin
            nv_cnt <= nv_cnt + 1;
        end
    end

    // Verdict and end of run, reached from the tests or the watchdog
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One command line with its expected answer
    task automatic do_cmd(input string s, input sscmd_resp_type k,
                          input logic [63:0] v, input bit chkv);
        host.cmd(s, r, got);
        `CHECK({s, " answered"}, 1'b1, got);
        `CHECK({s, " kind"}, k, r.kind);
        if (chkv) begin
            `CHECK({s, " value"}, v, r.value);
        end
    endtask

    // One cycle wake or sleep event, then time to settle
    task automatic event_pulse(input bit wake);
        @(negedge clk);
        wake_ev  = wake;
        sleep_ev = !wake;
        @(negedge clk);
        wake_ev  = 1'b0;
        sleep_ev = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // One received sync message from a neighbour
    task automatic send_sync(input bit nw, input logic [31:0] sl, wk);
        @(negedge clk);
        sync_rx = '{1'b1, nw, sl, wk};
        @(negedge clk);
        sync_rx.valid   = 1'b0;
        sync_rx.sleep_t = ~sync_rx.sleep_t;
        sync_rx.wake_t  = ~sync_rx.wake_t;
        repeat (2) @(negedge clk);
    endtask

    // Watchdog: the tests need a few hundred cycles at most
    initial begin
        #800000;
        failures++;
        $display("Error watchdog expected 0 seen 1");
        conclude();
    end

    initial begin
        rst      = 1'b1;
        api      = 1'b0;
        sup      = 1'b0;
        wake_ev  = 1'b0;
        sleep_ev = 1'b0;
        sync_rx  = '0;
        fact     = '{4'h8, 32'h00000100, 32'h00000040, 8'h02};
        repeat (3) @(negedge clk);
        rst = 1'b0;
        `CHECK("active cfg", 76'h0, act);
        `CHECK("missed", 16'h0000, missed);
        `CHECK("reset pulse", 1'b0, mrst);
        // Region bitfield, bit 0 and bit 31 set among the rest
        do_cmd("AF", SSCMD_RESP_VALUE, `SSCMD_AF_MASK_DEF, 1);
        foreach (bad[i]) begin
            do_cmd(bad[i], SSCMD_RESP_ERROR, 64'h0, 0);
        end
        // Defaults go to pending, apply puts them in effect
        do_cmd("RE", SSCMD_RESP_OK, 64'h0, 0);
        do_cmd("AC", SSCMD_RESP_OK, 64'h0, 0);
        `CHECK("active after apply", fact, act);
        do_cmd("WR", SSCMD_RESP_OK, 64'h0, 0);
        @(negedge clk); // Let the pulse counter see the write strobe
        `CHECK("save pulses", 1, nv_cnt);
        `CHECK("stored cfg", fact, nv);
        do_cmd("OS", SSCMD_RESP_VALUE, 64'h100, 1);
        do_cmd("OW", SSCMD_RESP_VALUE, 64'h40, 1);
        // Status frames on wake and before sleep in API mode
        api = 1'b1;
        event_pulse(1'b1);
        `CHECK("wake frames", 1, frames);
        `CHECK("first broadcast", 1, tx_cnt);
        `CHECK("wake frame kind", 1'b1, last_wake);
        `CHECK("missed after wake", 16'h0001, missed);
        do_cmd("MS", SSCMD_RESP_VALUE, 64'h1, 1);
        event_pulse(1'b0);
        `CHECK("sleep frames", 2, frames);
        `CHECK("sleep frame kind", 1'b0, last_wake);
        // Changed wake time: coordinator, broadcast at next wake
        do_cmd("SM8", SSCMD_RESP_OK, 64'h0, 0);
        do_cmd("ST48", SSCMD_RESP_OK, 64'h0, 0);
        do_cmd("AC", SSCMD_RESP_OK, 64'h0, 0);
        do_cmd("OW", SSCMD_RESP_VALUE, 64'h48, 1);
        `CHECK("coordinator", 1'b1, coord);
        do_cmd("SS", SSCMD_RESP_VALUE, 64'hb, 1);
        `CHECK("status coord bit", 1'b1, r.value[0]);
        event_pulse(1'b1);
        `CHECK("broadcasts", 2, tx_cnt);
        `CHECK("broadcast cfg", 64'h0000010000000048,
               {last_tx.sleep_t, last_tx.wake_t});
        // Support node rejects a stale sync and answers with its own
        sup = 1'b1;
        send_sync(1'b0, 32'h200, 32'h20);
        `CHECK("reply sync", 3, tx_cnt);
        `CHECK("reply cfg", 64'h0000010000000048,
               {last_tx.sleep_t, last_tx.wake_t});
        `CHECK("kept wake", 32'h48, act.wake_t);
        // Newer network settings are adopted
        sup = 1'b0;
        send_sync(1'b1, 32'h300, 32'h30);
        `CHECK("adopted", 64'h0000030000000030,
               {act.sleep_t, act.wake_t});
        `CHECK("missed cleared", 16'h0000, missed);
        // Reset command: OK first, module reset a fixed time later
        do_cmd("FR", SSCMD_RESP_OK, 64'h0, 0);
        n = 0;
        while (mrst !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHECK("reset delay", RSTC, n);
        @(negedge clk);
        `CHECK("reset pulse width", 1'b0, mrst);
        conclude();
    end
endmodule // tb_top
